// ==== dvi_map.svh ====
// Constants for the dual vernier interval interpolator: timing figures and widths.
// Assumes inclusion by bare name from design and verification files.
`ifndef DVI_MAP_SVH
`define DVI_MAP_SVH

`define DVI_REF_PERIOD_PS  5000
`define DVI_INTERP_N       256
`define DVI_CORE_PERIOD_PS 4000
`define DVI_CNT_W          16
`define DVI_RES_W          32
`define DVI_STAT_W         48
`define DVI_SQ_W           64
`define DVI_NUM_W          16
`define DVI_COINC_MARGIN   2
`define DVI_PIN_W          7

`endif

// ==== dvi_pkg.sv ====
// Types for the dual vernier interval interpolator.
// Assumes dvi_map.svh is on the include path.
`include "dvi_map.svh"

package dvi_pkg;

   typedef enum logic [1:0]
   {
      DVI_IDLE = 2'b00,
      DVI_RUN  = 2'b01,
      DVI_CALC = 2'b10
   } dvi_state_t;

   // Pin group, all asynchronous to core_clk
   typedef struct packed
   {
      logic ref_clk;
      logic stop_coinc;
      logic start_coinc;
      logic stop_osc;
      logic start_osc;
      logic stop_evt;
      logic start_evt;
   } dvi_pins_t;

   // Running statistics over single-shot results
   typedef struct packed
   {
      logic signed [`DVI_RES_W-1:0]  max_val;
      logic signed [`DVI_RES_W-1:0]  min_val;
      logic signed [`DVI_STAT_W-1:0] sum;
      logic        [`DVI_SQ_W-1:0]   sum_sq;
      logic        [`DVI_NUM_W-1:0]  count;
   } dvi_stats_t;

endpackage

// ==== dvi_edge_sync.sv ====
// Two-stage synchroniser with rising-edge detection for a vector of pins.
// Assumes inputs are asynchronous to clk; edge pulse is one clk cycle.
`timescale 1ns/1ps

module dvi_edge_sync #(
   parameter int WIDTH = 7
)(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   // ==========================================================
   // Synchroniser: meta_reg feeds only sync_reg
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end
      else if (ce)
      begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise  = sync_reg & ~prev_reg;

endmodule // dvi_edge_sync

// ==== dvi_interpolator.sv ====
// Dual vernier interval interpolator: counts vernier and reference pulses to
// coincidence and forms a signed single-shot interval in units of T0/N.
// Assumes the vernier oscillators and coincidence detectors are external and
// that all pins are asynchronous to core_clk and far slower than it.
//
// What this block does
// - Count start pulses, stop pulses, and reference pulses between coincidences.
// - Interval equals T0 times reference count plus (1+1/N) times count difference.
// - Reference period 5 ns, factor 256, one result step is 5/256 ns.
// - Resolve a single interval to about 20 ps without averaging.
// - Work whether start or stop oscillator launches first.
// - Stop before start gives a negative interval.
// - Accumulate max, min, sum and sum of squares over results.
`timescale 1ns/1ps
`include "dvi_map.svh"

module dvi_interpolator #(
   parameter int INTERP_N = `DVI_INTERP_N,
   parameter int CNT_W    = `DVI_CNT_W,
   parameter int RES_W    = `DVI_RES_W
)(
   input  wire logic                           core_clk,
   input  wire logic                           rstn,
   input  wire logic                           ce,
   input  wire logic                           start_evt,
   input  wire logic                           stop_evt,
   input  wire logic                           start_osc,
   input  wire logic                           stop_osc,
   input  wire logic                           start_coinc,
   input  wire logic                           stop_coinc,
   input  wire logic                           ref_clk,
   input  wire logic                           stats_clear,
   output logic                                busy,
   output logic                                result_valid,
   output logic signed [RES_W-1:0]             result,
   output logic                                result_neg,
   output logic                                meas_error,
   output dvi_pkg::dvi_stats_t                 stats
);

   // ==========================================================
   // Constants
   localparam int REF_PS   = `DVI_REF_PERIOD_PS;
   localparam int LSB_FS   = (REF_PS * 1000) / INTERP_N;
   localparam logic [CNT_W-1:0] COINC_LIMIT = CNT_W'(INTERP_N + `DVI_COINC_MARGIN);
   localparam logic signed [RES_W-1:0] N_S  = RES_W'(INTERP_N);
   localparam logic signed [RES_W-1:0] N1_S = RES_W'(INTERP_N + 1);

   // Interval in steps of T0/N: N*n0 + (N+1)*(n1-n2), n0 already signed
   function automatic logic signed [RES_W-1:0] interval_steps(
      input logic signed [CNT_W:0] n0,
      input logic [CNT_W-1:0]      n1,
      input logic [CNT_W-1:0]      n2
   );
      logic signed [RES_W-1:0] a;
      logic signed [RES_W-1:0] d;
      a = RES_W'(n0);
      d = RES_W'($signed({1'b0, n1})) - RES_W'($signed({1'b0, n2}));
      return RES_W'(a * N_S) + RES_W'(d * N1_S);
   endfunction

   // ==========================================================
   // Pin synchronisation
   dvi_pkg::dvi_pins_t pins;
   dvi_pkg::dvi_pins_t rise;

   assign pins.ref_clk     = ref_clk;
   assign pins.stop_coinc  = stop_coinc;
   assign pins.start_coinc = start_coinc;
   assign pins.stop_osc    = stop_osc;
   assign pins.start_osc   = start_osc;
   assign pins.stop_evt    = stop_evt;
   assign pins.start_evt   = start_evt;

   dvi_edge_sync #(
      .WIDTH (`DVI_PIN_W)
   ) u_sync (
      .clk   (core_clk),
      .rstn  (rstn),
      .ce    (ce),
      .pin   (pins),
      .level (),
      .rise  (rise)
   );

   // ==========================================================
   // State
   dvi_pkg::dvi_state_t state_reg;
   dvi_pkg::dvi_state_t state_next;
   logic                start_seen_reg;
   logic                stop_seen_reg;
   logic                start_done_reg;
   logic                stop_done_reg;
   logic                stop_first_reg;
   logic [CNT_W-1:0]    n1_reg;
   logic [CNT_W-1:0]    n2_reg;
   logic [CNT_W-1:0]    n0_reg;
   logic                valid_reg;
   logic                error_reg;
   logic signed [RES_W-1:0] result_reg;
   logic                neg_reg;
   dvi_pkg::dvi_stats_t stats_reg;

   // ==========================================================
   // Decode
   wire in_run      = (state_reg == dvi_pkg::DVI_RUN);
   wire in_idle     = (state_reg == dvi_pkg::DVI_IDLE);
   wire in_calc     = (state_reg == dvi_pkg::DVI_CALC);
   // Either event may open the measurement
   wire arm_start   = (in_idle | in_run) & rise.start_evt & ~start_seen_reg;
   wire arm_stop    = (in_idle | in_run) & rise.stop_evt & ~stop_seen_reg;
   wire start_live  = in_run & start_seen_reg & ~start_done_reg;
   wire stop_live   = in_run & stop_seen_reg & ~stop_done_reg;
   // Oscillator edge in the coincidence cycle is still counted
   wire start_tick  = start_live & rise.start_osc;
   wire stop_tick   = stop_live & rise.stop_osc;
   wire start_hit   = start_live & rise.start_coinc;
   wire stop_hit    = stop_live & rise.stop_coinc;
   wire start_fin   = start_done_reg | start_hit;
   wire stop_fin    = stop_done_reg | stop_hit;
   // Reference counted only between the two coincidences
   wire ref_tick    = in_run & (start_done_reg ^ stop_done_reg) & rise.ref_clk;
   // Stop coincidence reached first means the reference count n0 is taken as negative
   wire stop_first  = stop_hit & ~start_done_reg & ~start_hit;
   // Missing coincidence, or a reference count about to wrap, aborts the measurement
   wire overrun     = (start_live & (n1_reg >= COINC_LIMIT))
                    | (stop_live & (n2_reg >= COINC_LIMIT))
                    | (in_run & (&n0_reg));

   wire signed [CNT_W:0] n0_signed = stop_first_reg ? -$signed({1'b0, n0_reg})
                                                     :  $signed({1'b0, n0_reg});
   wire signed [RES_W-1:0] interval = interval_steps(n0_signed, n1_reg, n2_reg);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         dvi_pkg::DVI_IDLE:
            if (arm_start | arm_stop)
               state_next = dvi_pkg::DVI_RUN;
         dvi_pkg::DVI_RUN:
            if (overrun)
               state_next = dvi_pkg::DVI_IDLE;
            else if (start_fin & stop_fin)
               state_next = dvi_pkg::DVI_CALC;
         dvi_pkg::DVI_CALC:
            state_next = dvi_pkg::DVI_IDLE;
         default:
            state_next = dvi_pkg::DVI_IDLE;
      endcase
   end

   // ==========================================================
   // Sequencer and channel flags
   wire clr_all = in_calc | (in_run & overrun);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg      <= dvi_pkg::DVI_IDLE;
         start_seen_reg <= 1'b0;
         stop_seen_reg  <= 1'b0;
         start_done_reg <= 1'b0;
         stop_done_reg  <= 1'b0;
         stop_first_reg <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         if (clr_all)
         begin
            start_seen_reg <= 1'b0;
            stop_seen_reg  <= 1'b0;
            start_done_reg <= 1'b0;
            stop_done_reg  <= 1'b0;
            stop_first_reg <= 1'b0;
         end
         else
         begin
            start_seen_reg <= start_seen_reg | arm_start;
            stop_seen_reg  <= stop_seen_reg | arm_stop;
            start_done_reg <= start_fin;
            stop_done_reg  <= stop_fin;
            stop_first_reg <= stop_first_reg | stop_first;
         end
      end
   end

   // ==========================================================
   // Counters, cleared after every result or abort
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         n1_reg <= '0;
         n2_reg <= '0;
         n0_reg <= '0;
      end
      else if (ce)
      begin
         if (clr_all)
         begin
            n1_reg <= '0;
            n2_reg <= '0;
            n0_reg <= '0;
         end
         else
         begin
            n1_reg <= n1_reg + CNT_W'(start_tick);
            n2_reg <= n2_reg + CNT_W'(stop_tick);
            n0_reg <= n0_reg + CNT_W'(ref_tick);
         end
      end
   end

   // ==========================================================
   // Result and one-cycle strobes
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         valid_reg  <= 1'b0;
         error_reg  <= 1'b0;
         result_reg <= '0;
         neg_reg    <= 1'b0;
      end
      else if (ce)
      begin
         valid_reg <= in_calc;
         error_reg <= in_run & overrun;
         if (in_calc)
         begin
            result_reg <= interval;
            neg_reg    <= interval[RES_W-1];
         end
      end
   end

   // ==========================================================
   // Statistics; std deviation is left to software since it needs a root
   wire signed [`DVI_STAT_W-1:0] res_ext = `DVI_STAT_W'(result_reg);
   // Square at full width; a 32-bit product would wrap for large intervals
   wire signed [`DVI_SQ_W-1:0]   res_wide = `DVI_SQ_W'(result_reg);
   wire        [`DVI_SQ_W-1:0]   res_sq   = res_wide * res_wide;
   wire                          first_s = (stats_reg.count == '0);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         stats_reg <= '0;
      else if (ce)
      begin
         if (stats_clear)
            stats_reg <= '0;
         else if (valid_reg)
         begin
            if (first_s || result_reg > stats_reg.max_val)
               stats_reg.max_val <= result_reg;
            if (first_s || result_reg < stats_reg.min_val)
               stats_reg.min_val <= result_reg;
            stats_reg.sum    <= stats_reg.sum + res_ext;
            stats_reg.sum_sq <= stats_reg.sum_sq + res_sq;
            stats_reg.count  <= stats_reg.count + `DVI_NUM_W'(1);
         end
      end
   end

   // ==========================================================
   // Outputs
   logic busy_reg;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         busy_reg <= 1'b0;
      else if (ce)
         busy_reg <= (state_next != dvi_pkg::DVI_IDLE);
   end

   assign busy         = busy_reg;
   assign result_valid = valid_reg;
   assign result       = result_reg;
   assign result_neg   = neg_reg;
   assign meas_error   = error_reg;
   assign stats        = stats_reg;

   // Result step in femtoseconds, for reference only
   localparam int RESULT_LSB_FS = LSB_FS;

endmodule // dvi_interpolator

// ==== dvi_interpolator_sva.sv ====
// Checker for dvi_interpolator: strobes, sign, result hold and statistics.
// Assumes it is bound to dvi_interpolator and sees only that module's ports.
`timescale 1ns/1ps

module dvi_interpolator_sva #(
   parameter int RES_W = 32
)(
   input wire logic                     core_clk,
   input wire logic                     rstn,
   input wire logic                     ce,
   input wire logic                     start_evt,
   input wire logic                     stats_clear,
   input wire logic                     busy,
   input wire logic                     result_valid,
   input wire logic signed [RES_W-1:0]  result,
   input wire logic                     result_neg,
   input wire logic                     meas_error,
   input wire dvi_pkg::dvi_stats_t      stats
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ==========
   // Sequences
   sequence s_launch;
      ce && !busy && $rose(start_evt);
   endsequence
   sequence s_counted;
      (result_valid && !stats_clear) ##1 !stats_clear;
   endsequence

   // ==========
   // Properties
   // Pin passes two sync flops, then rise is decoded combinationally, before the state leaves idle
   property p_launch_busy;
      s_launch |-> ##[1:6] busy;
   endproperty
   a_launch_busy: assert property (p_launch_busy) else $error("busy missing after start");
   property p_valid_once;
      result_valid |=> !result_valid;
   endproperty
   a_valid_once: assert property (p_valid_once) else $error("valid longer than one cycle");
   property p_sign;
      result_valid |-> result_neg == result[RES_W-1];
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag disagrees with result");
   property p_hold;
      !result_valid |-> $stable(result) && $stable(result_neg);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without valid");
   property p_valid_idle;
      result_valid |-> !busy && !meas_error;
   endproperty
   a_valid_idle: assert property (p_valid_idle) else $error("busy at valid");
   property p_err_abort;
      meas_error |-> !busy ##1 !meas_error;
   endproperty
   a_err_abort: assert property (p_err_abort) else $error("abort pulse wrong");
   property p_count;
      s_counted |=> stats.count == $past(stats.count, 2) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("result count not advanced");
   property p_clear;
      stats_clear |=> stats.count == 16'h0000 && stats.sum == 48'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("statistics not cleared");
   property p_order;
      stats.count != 16'h0000 |-> stats.max_val >= stats.min_val;
   endproperty
   a_order: assert property (p_order) else $error("maximum below minimum");
endmodule // dvi_interpolator_sva

bind dvi_interpolator dvi_interpolator_sva #(
   .RES_W(RES_W)
) i_sva (
   .core_clk(core_clk), .rstn(rstn), .ce(ce), .start_evt(start_evt),
   .stats_clear(stats_clear), .busy(busy), .result_valid(result_valid),
   .result(result), .result_neg(result_neg), .meas_error(meas_error), .stats(stats)
);

// ==== dvi_vernier_model.sv ====
// Far side model: free reference clock and two phase-started vernier channels.
// Assumes the bench calls run_chan; oscillators stand still outside frames.
`timescale 1ns/1ps
`include "dvi_map.svh"

module dvi_vernier_model (
   output dvi_pkg::dvi_pins_t pins
);
   localparam real T0_NS = 32.0;
   localparam real TV_NS = T0_NS + T0_NS / `DVI_INTERP_N;
   logic [`DVI_PIN_W-1:0] pin_v;

   assign pins = pin_v;

   initial
   begin
      pin_v = '0;
      forever #(T0_NS / 2) pin_v[6] = ~pin_v[6];
   end

   // ==========
   // Channel c: 0 start, 1 stop
   // Oscillator stops before coincidence so the pulse count is exact
   task automatic run_chan(input int c, input int n, input int dly_ns, input bit coinc);
      #(dly_ns);
      pin_v[c] = 1'b1;
      #(T0_NS / 2) pin_v[c] = 1'b0;
      repeat (n)
      begin
         pin_v[2+c] = 1'b1;
         #(TV_NS / 2) pin_v[2+c] = 1'b0;
         #(TV_NS / 2);
      end
      if (coinc)
      begin
         @(posedge pin_v[6]);
         #(T0_NS / 2) pin_v[4+c] = 1'b1;
         #(T0_NS / 2) pin_v[4+c] = 1'b0;
      end
   endtask
endmodule // dvi_vernier_model

// ==== dvi_interpolator_test.sv ====
// Bench for dvi_interpolator: intervals in both orders, abort, statistics.
// Assumes dvi_vernier_model drives every pin; ce is held high.
`timescale 1ns/1ps
`include "dvi_map.svh"

module dvi_interpolator_test;
   logic                          core_clk;
   logic                          rstn;
   logic                          stats_clear;
   logic                          busy;
   logic                          result_valid;
   logic signed [`DVI_RES_W-1:0]  result;
   logic                          result_neg;
   logic                          meas_error;
   dvi_pkg::dvi_stats_t           stats;
   dvi_pkg::dvi_pins_t            pins;
   int                            err_total;
   int                            samples_checked;
   realtime                       t_start;
   realtime                       t_stop;
   logic signed [`DVI_RES_W-1:0]  exp_max;
   logic signed [`DVI_RES_W-1:0]  exp_min;
   logic signed [`DVI_STAT_W-1:0] exp_sum;
   logic [`DVI_NUM_W-1:0]         exp_cnt;
   logic [`DVI_SQ_W-1:0]          exp_sq;

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   dvi_vernier_model i_far (.pins(pins));

   dvi_interpolator i_dut (
      .core_clk(core_clk), .rstn(rstn), .ce(1'b1),
      .start_evt(pins.start_evt), .stop_evt(pins.stop_evt),
      .start_osc(pins.start_osc), .stop_osc(pins.stop_osc),
      .start_coinc(pins.start_coinc), .stop_coinc(pins.stop_coinc),
      .ref_clk(pins.ref_clk), .stats_clear(stats_clear), .busy(busy),
      .result_valid(result_valid), .result(result), .result_neg(result_neg),
      .meas_error(meas_error), .stats(stats)
   );

   // Coincidences sit mid-way between reference edges, so the gap is whole periods
   always @(posedge pins.start_coinc) t_start = $realtime;
   always @(posedge pins.stop_coinc) t_stop = $realtime;

   // ==========
   // Common tasks
   task automatic check(input bit ok, input string msg);
      samples_checked++;
      if (!ok)
      begin
         err_total++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_done(output bit v, output bit e);
      v = 1'b0;
      e = 1'b0;
      repeat (20000)
      begin
         @(posedge core_clk);
         #1;
         v = (result_valid === 1'b1);
         e = (meas_error === 1'b1);
         if (v || e)
            return;
      end
      $display("BAD %0t timeout waiting for result", $time);
      err_total++;
      close_out();
   endtask

   // ==========
   // Scenarios
   task automatic measure(input int n1, input int n2, input int ds, input int dp);
      logic signed [`DVI_RES_W-1:0] want;
      bit v;
      bit e;
      fork
         i_far.run_chan(0, n1, ds, 1'b1);
         i_far.run_chan(1, n2, dp, 1'b1);
      join_none
      wait_done(v, e);
      want = `DVI_INTERP_N * int'((t_stop - t_start) / 32.0) + (`DVI_INTERP_N + 1) * (n1 - n2);
      check(v && result === want, "interval");
      check(result_neg === (want < 0), "sign");
      @(posedge core_clk);
      #1;
      check(result_valid === 1'b0 && busy === 1'b0, "strobe");
      if (exp_cnt == 0 || want > exp_max)
         exp_max = want;
      if (exp_cnt == 0 || want < exp_min)
         exp_min = want;
      exp_sum = exp_sum + want;
      exp_sq = exp_sq + `DVI_SQ_W'(longint'(want) * longint'(want));
      exp_cnt++;
   endtask

   // Start channel never reaches coincidence
   task automatic sc_abort();
      bit v;
      bit e;
      fork
         i_far.run_chan(0, `DVI_INTERP_N + `DVI_COINC_MARGIN + 1, 0, 1'b0);
      join_none
      wait_done(v, e);
      check(e && !v && busy === 1'b0, "abort");
      repeat (200) @(posedge core_clk);
      #1;
      check(result_valid === 1'b0 && busy === 1'b0, "idle after abort");
   endtask

   task automatic sc_stats();
      check(stats.count === exp_cnt && stats.max_val === exp_max, "count max");
      check(stats.min_val === exp_min && stats.sum === exp_sum, "min sum");
      check(stats.sum_sq === exp_sq, "sum of squares");
      @(posedge core_clk);
      #1 stats_clear = 1'b1;
      @(posedge core_clk);
      #1 stats_clear = 1'b0;
      @(posedge core_clk);
      #1;
      check(stats.count === 16'h0000 && stats.sum === 48'h0 && stats.sum_sq === 64'h0, "clear");
      exp_cnt = '0;
      exp_sum = '0;
      exp_sq = '0;
   endtask

   initial
   begin
      rstn = 1'b0;
      stats_clear = 1'b0;
      err_total = 0;
      samples_checked = 0;
      exp_cnt = '0;
      exp_sum = '0;
      exp_sq = '0;
      repeat (20) @(posedge core_clk);
      #1 rstn = 1'b1;
      check(busy === 1'b0 && result === '0 && stats.count === '0, "reset");
      repeat (4) @(posedge core_clk);
      measure(5, 30, 0, 100);
      measure(40, 12, 0, 300);
      measure(20, 20, 400, 0);
      sc_abort();
      sc_stats();
      measure(9, 3, 200, 0);
      sc_stats();
      close_out();
   end
endmodule // dvi_interpolator_test
